// >>> design/tocf_pkg.sv
// Purpose: constants, register map and option codes for the option controller
// Assumes: 50 MHz core clock, synchronous active-low reset
// Notes: register offsets are byte addresses of 32-bit words
package tocf_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS = 1000000;
  localparam int MS_PER_HOUR = 3600000;
  localparam int HOUR_MS_W = 22;
  localparam logic [7:0] MOVE_TIMEOUT_MS = 8'h64;
  localparam logic [7:0] BATT_LOW_PCT = 8'h0A;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_COMMIT = 8'h04;
  localparam logic [7:0] ADDR_BRK = 8'h08;
  localparam logic [7:0] ADDR_LIMITS = 8'h0C;
  localparam logic [7:0] ADDR_THR = 8'h10;
  localparam logic [7:0] ADDR_TIMES = 8'h14;
  localparam logic [7:0] ADDR_VACC = 8'h18;
  localparam logic [7:0] ADDR_CAL = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_HOURS = 8'h24;

  localparam int CFG_W = 17;
  localparam int CFG_SEAT = 0;
  localparam int CFG_IN1_LSB = 1;
  localparam int CFG_IN2 = 3;
  localparam int CFG_IN3 = 4;
  localparam int CFG_IN4_LSB = 5;
  localparam int CFG_HOUR = 7;
  localparam int CFG_BATT = 8;
  localparam int CFG_STKEY = 9;
  localparam int CFG_RAMP = 10;
  localparam int CFG_AUX_LSB = 11;
  localparam int CFG_PEDAL_LSB = 13;
  localparam int CFG_QI_LSB = 15;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam int TOP_LSB = 16;
  localparam int CAL_LOW_BIT = 0;
  localparam int CAL_HIGH_BIT = 1;

  localparam logic [15:0] VACC_RST = 16'hFF00;
  localparam logic [15:0] LIMITS_RST = 16'hFFFF;
  localparam logic [7:0] FULL_SCALE = 8'hFF;

  typedef enum logic [1:0] {IN1_THERMAL = 2'b00, IN1_CUTBACK = 2'b01,
    IN1_HANDBRAKE = 2'b10} tocf_in1_sel_t;
  typedef enum logic [1:0] {IN4_BELLY = 2'b00, IN4_SERVICE_BRAKE = 2'b01,
    IN4_EXCL_STEER = 2'b10} tocf_in4_sel_t;
  typedef enum logic [1:0] {AUX_BRAKE = 2'b00, AUX_STEER_CONTACTOR = 2'b01,
    AUX_EXCL_STEER = 2'b10, AUX_FREE = 2'b11} tocf_aux_mode_t;
  typedef enum logic [1:0] {PEDAL_NONE = 2'b00, PEDAL_DIGITAL = 2'b01,
    PEDAL_ANALOG = 2'b10} tocf_pedal_mode_t;
  typedef enum logic [1:0] {QI_NONE = 2'b00, QI_TIMED = 2'b01,
    QI_UNTIMED = 2'b10} tocf_qi_mode_t;
  typedef enum logic [1:0] {RAMP_IDLE = 2'b00, RAMP_TIMING = 2'b01,
    RAMP_DONE = 2'b10} tocf_ramp_state_t;
endpackage : tocf_pkg

// >>> design/tocf_lin_interp.sv
// Purpose: y = y0 + (y1 - y0) * num / den by a sequential divider
// Assumes: operands held steady; result refreshes every few cycles
// Notes: num above den is clamped, den of zero yields y1
`timescale 1ns/1ps
module tocf_lin_interp import tocf_pkg::*; (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] y0_in,
  input wire logic [7:0] y1_in,
  input wire logic [7:0] num_in,
  input wire logic [7:0] den_in,
  output logic [7:0] y_out
);
  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic [15:0] quo;
    logic [8:0] rem;
    logic [7:0] den;
    logic [7:0] base;
    logic neg;
    logic [7:0] y;
  } tocf_interp_state_t;

  tocf_interp_state_t r, n;

  always_comb begin
    logic [7:0] diff;
    logic [7:0] num_c;
    logic [8:0] rem_sh;
    logic [15:0] quo_sh;
    diff = '0;
    num_c = '0;
    rem_sh = '0;
    quo_sh = '0;
    n = r;
    if (!r.busy) begin
      num_c = (num_in > den_in) ? den_in : num_in;
      n.neg = y1_in < y0_in;
      diff = n.neg ? 8'(y0_in - y1_in) : 8'(y1_in - y0_in);
      n.base = y0_in;
      n.den = den_in;
      n.quo = diff * num_c;
      n.rem = '0;
      n.cnt = DIV_STEPS;
      if (den_in == '0) begin
        n.y = y1_in;
      end else begin
        n.busy = 1'b1;
      end
    end else begin
      rem_sh = {r.rem[7:0], r.quo[15]};
      quo_sh = {r.quo[14:0], 1'b0};
      if (rem_sh >= {1'b0, r.den}) begin
        rem_sh = 9'(rem_sh - {1'b0, r.den});
        quo_sh[0] = 1'b1;
      end
      n.rem = rem_sh;
      n.quo = quo_sh;
      n.cnt = 5'(r.cnt - 5'h01);
      if (r.cnt == 5'h01) begin
        n.busy = 1'b0;
        n.y = r.neg ? 8'(r.base - quo_sh[7:0]) : 8'(r.base + quo_sh[7:0]);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign y_out = r.y;
endmodule : tocf_lin_interp

// >>> design/tocf_hour_meter.sv
// Purpose: hour counter advanced by millisecond ticks while enabled
// Assumes: tick_in is a one-cycle pulse per millisecond
// Notes: wraps silently after the top hour value
`timescale 1ns/1ps
module tocf_hour_meter import tocf_pkg::*; #(
  parameter int TICKS_PER_HOUR = MS_PER_HOUR
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic run_in,
  output logic [15:0] hours_out
);
  typedef struct packed {
    logic [HOUR_MS_W-1:0] ms;
    logic [15:0] hours;
  } tocf_hour_state_t;

  tocf_hour_state_t r, n;

  always_comb begin
    n = r;
    if (tick_in && run_in) begin
      if (r.ms == HOUR_MS_W'(TICKS_PER_HOUR - 1)) begin
        n.ms = '0;
        n.hours = 16'(r.hours + 16'h0001);
      end else begin
        n.ms = HOUR_MS_W'(r.ms + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign hours_out = r.hours;
endmodule : tocf_hour_meter

// >>> design/tocf_option_ctrl.sv
// Purpose: option selection, input remap, coil control, braking and throttle maps
// Assumes: all pins synchronous to core_clk_in; analog values pre-digitised
// Notes: register port answers reads one cycle later; options apply on commit
`timescale 1ns/1ps
module tocf_option_ctrl import tocf_pkg::*; #(
  parameter int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS,
  parameter int TICKS_PER_HOUR = MS_PER_HOUR
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic key_in,
  input wire logic fwd_in,
  input wire logic bwd_in,
  input wire logic presence_in,
  input wire logic cfg_in1_in,
  input wire logic cfg_in2_in,
  input wire logic cfg_in3_in,
  input wire logic cfg_in4_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic [7:0] accel_pot_in,
  input wire logic [7:0] brake_pot_in,
  input wire logic [7:0] motor_temp_in,
  input wire logic [7:0] batt_level_in,
  output logic tiller_req_out,
  output logic seat_occ_out,
  output logic thermal_sel_out,
  output logic speed_cutback_one_out,
  output logic speed_cutback_two_out,
  output logic speed_cutback_three_out,
  output logic handbrake_out,
  output logic inch_fwd_out,
  output logic inch_bwd_out,
  output logic service_brake_out,
  output logic excl_steer_req_out,
  output logic aux_coil_out,
  output logic steer_contactor_out,
  output logic ramp_hold_out,
  output logic bridge_release_out,
  output logic batt_alarm_out,
  output logic [7:0] current_limit_out,
  output logic temp_warn_out,
  output logic qi_active_out,
  output logic brake_active_out,
  output logic [7:0] brake_level_out,
  output logic [7:0] throttle_out
);
  typedef struct packed {
    logic [CFG_W-1:0] cfg_shadow;
    logic [CFG_W-1:0] cfg;
    logic [15:0] brk_par;
    logic [15:0] limits;
    logic [23:0] thr_par;
    logic [31:0] times;
    logic [15:0] vacc;
    logic [7:0] brk_min;
    logic [7:0] brk_max;
    logic cal_refused;
    logic [31:0] rdata;
    logic enc_a;
    logic enc_b;
    logic moving;
    logic [7:0] move_ms;
    logic [15:0] tick_cnt;
    logic tick;
    tocf_ramp_state_t ramp_st;
    logic [15:0] ramp_ms;
    logic qi_active;
    logic [15:0] qi_ms;
    logic belly_prev;
    logic batt_alarm;
    logic temp_warn;
    logic [7:0] cur_limit;
    logic aux_coil;
    logic steer_cont;
    logic ramp_hold;
    logic bridge_release;
    logic brake_active;
    logic [7:0] brake_level;
    logic [7:0] throttle;
    logic [10:0] remap;
  } tocf_ctrl_state_t;

  tocf_ctrl_state_t r, n;
  tocf_in1_sel_t in1_sel;
  tocf_in4_sel_t in4_sel;
  tocf_aux_mode_t aux_mode;
  tocf_pedal_mode_t pedal_mode;
  tocf_qi_mode_t qi_mode;
  logic [7:0] thr_y0, thr_y1, thr_num, thr_den, thr_y;
  logic [7:0] brk_num, brk_den, brk_y;
  logic thr_zero;
  logic [15:0] hours;
  logic hour_run;

  assign in1_sel = tocf_in1_sel_t'(r.cfg[CFG_IN1_LSB +: 2]);
  assign in4_sel = tocf_in4_sel_t'(r.cfg[CFG_IN4_LSB +: 2]);
  assign aux_mode = tocf_aux_mode_t'(r.cfg[CFG_AUX_LSB +: 2]);
  assign pedal_mode = tocf_pedal_mode_t'(r.cfg[CFG_PEDAL_LSB +: 2]);
  assign qi_mode = tocf_qi_mode_t'(r.cfg[CFG_QI_LSB +: 2]);

  // accelerator curve: deadband above the low point, one breakpoint
  always_comb begin
    logic [7:0] vmin, vmax, dz, xp, yp, lo, acc;
    logic [8:0] lo9;
    vmin = r.vacc[LO_LSB +: 8];
    vmax = r.vacc[HI_LSB +: 8];
    dz = r.thr_par[LO_LSB +: 8];
    xp = r.thr_par[HI_LSB +: 8];
    yp = r.thr_par[TOP_LSB +: 8];
    lo9 = {1'b0, vmin} + {1'b0, dz};
    lo = lo9[8] ? FULL_SCALE : lo9[7:0];
    acc = (accel_pot_in > vmax) ? vmax : accel_pot_in;
    thr_zero = acc <= lo;
    if (acc < xp) begin
      thr_y0 = '0;
      thr_y1 = yp;
      thr_num = 8'(acc - lo);
      thr_den = 8'(xp - lo);
    end else begin
      thr_y0 = yp;
      thr_y1 = FULL_SCALE;
      thr_num = 8'(acc - xp);
      thr_den = 8'(vmax - xp);
    end
  end

  // brake pot position within the calibrated span
  always_comb begin
    logic [7:0] pot;
    pot = brake_pot_in;
    if (pot < r.brk_min) begin
      pot = r.brk_min;
    end
    if (pot > r.brk_max) begin
      pot = r.brk_max;
    end
    brk_num = 8'(pot - r.brk_min);
    brk_den = (r.brk_max > r.brk_min) ? 8'(r.brk_max - r.brk_min) : '0;
  end

  tocf_lin_interp u_thr_interp (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .y0_in(thr_y0),
    .y1_in(thr_y1),
    .num_in(thr_num),
    .den_in(thr_den),
    .y_out(thr_y)
  );

  tocf_lin_interp u_brk_interp (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .y0_in(r.brk_par[LO_LSB +: 8]),
    .y1_in(r.brk_par[HI_LSB +: 8]),
    .num_in(brk_num),
    .den_in(brk_den),
    .y_out(brk_y)
  );

  tocf_hour_meter #(.TICKS_PER_HOUR(TICKS_PER_HOUR)) u_hours (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .tick_in(r.tick),
    .run_in(hour_run),
    .hours_out(hours)
  );

  // hours follow the key alone, or the key while travelling
  assign hour_run = key_in && (r.cfg[CFG_HOUR] || fwd_in || bwd_in || r.moving);

  always_comb begin
    logic dir_req, svc_sw, excl_sw, belly_sw, brake_press, count_while_switched_on_steer;
    dir_req = fwd_in || bwd_in;
    svc_sw = (in4_sel == IN4_SERVICE_BRAKE) && cfg_in4_in;
    excl_sw = (in4_sel == IN4_EXCL_STEER) && cfg_in4_in;
    belly_sw = (in4_sel == IN4_BELLY) && cfg_in4_in;
    brake_press = svc_sw || (pedal_mode == PEDAL_ANALOG && brake_pot_in > r.brk_min);
    count_while_switched_on_steer = r.cfg[CFG_STKEY] && key_in;
    n = r;
    n.rdata = '0;

    // input remapping
    n.remap[0] = presence_in && !r.cfg[CFG_SEAT];
    n.remap[1] = presence_in && r.cfg[CFG_SEAT];
    n.remap[2] = in1_sel == IN1_THERMAL;
    n.remap[3] = (in1_sel == IN1_CUTBACK) && cfg_in1_in;
    n.remap[4] = (in1_sel == IN1_HANDBRAKE) && cfg_in1_in;
    n.remap[5] = !r.cfg[CFG_IN2] && cfg_in2_in;
    n.remap[6] = r.cfg[CFG_IN2] && cfg_in2_in;
    n.remap[7] = !r.cfg[CFG_IN3] && cfg_in3_in;
    n.remap[8] = r.cfg[CFG_IN3] && cfg_in3_in;
    n.remap[9] = svc_sw;
    n.remap[10] = excl_sw;

    // millisecond tick
    n.tick = 1'b0;
    if (r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = 16'(r.tick_cnt + 16'h0001);
    end

    // movement from either encoder phase changing
    n.enc_a = enc_a_in;
    n.enc_b = enc_b_in;
    if ((enc_a_in != r.enc_a) || (enc_b_in != r.enc_b)) begin
      n.moving = 1'b1;
      n.move_ms = '0;
    end else if (r.tick && r.moving) begin
      if (r.move_ms == 8'(MOVE_TIMEOUT_MS - 8'h01)) begin
        n.moving = 1'b0;
      end else begin
        n.move_ms = 8'(r.move_ms + 8'h01);
      end
    end

    // battery and temperature
    n.batt_alarm = r.cfg[CFG_BATT] && (batt_level_in <= BATT_LOW_PCT);
    n.cur_limit = n.batt_alarm ? {1'b0, r.limits[LO_LSB + 1 +: 7]}
                               : r.limits[LO_LSB +: 8];
    n.temp_warn = (in1_sel == IN1_THERMAL) &&
                  (motor_temp_in > r.limits[HI_LSB +: 8]);

    // roll-away timing after travel requests stop
    unique case (r.ramp_st)
      RAMP_IDLE: begin
        if (!dir_req && thr_zero && r.moving) begin
          n.ramp_st = RAMP_TIMING;
          n.ramp_ms = '0;
        end
      end
      RAMP_TIMING: begin
        if (dir_req || !thr_zero) begin
          n.ramp_st = RAMP_IDLE;
        end else if (r.tick) begin
          if (r.ramp_ms >= r.times[LO_LSB +: 16]) begin
            n.ramp_st = RAMP_DONE;
          end else begin
            n.ramp_ms = 16'(r.ramp_ms + 16'h0001);
          end
        end
      end
      RAMP_DONE: begin
        if (dir_req || !thr_zero) begin
          n.ramp_st = RAMP_IDLE;
        end
      end
      default: n.ramp_st = RAMP_IDLE;
    endcase
    n.ramp_hold = r.cfg[CFG_RAMP] && (r.ramp_st == RAMP_TIMING);
    n.bridge_release = (aux_mode == AUX_BRAKE) && (r.ramp_st == RAMP_DONE);

    // auxiliary coil and steering contactor
    n.aux_coil = 1'b0;
    n.steer_cont = 1'b0;
    unique case (aux_mode)
      AUX_BRAKE: begin
        n.aux_coil = key_in && (dir_req || !thr_zero ||
                     r.ramp_st == RAMP_TIMING);
      end
      AUX_STEER_CONTACTOR: begin
        n.steer_cont = key_in && (dir_req || brake_press || r.moving ||
                       count_while_switched_on_steer);
      end
      AUX_EXCL_STEER: begin
        n.aux_coil = key_in && (excl_sw || count_while_switched_on_steer);
      end
      AUX_FREE: begin
        n.aux_coil = 1'b0;
      end
    endcase

    // pedal braking
    n.brake_active = 1'b0;
    n.brake_level = '0;
    unique case (pedal_mode)
      PEDAL_ANALOG: begin
        n.brake_active = thr_zero && ((in4_sel == IN4_SERVICE_BRAKE) ? svc_sw
                         : brake_pot_in > r.brk_min);
        n.brake_level = n.brake_active ? brk_y : '0;
      end
      PEDAL_DIGITAL: begin
        n.brake_active = thr_zero && svc_sw;
        n.brake_level = n.brake_active ? r.brk_par[HI_LSB +: 8] : '0;
      end
      PEDAL_NONE: begin
        n.brake_active = 1'b0;
      end
      default: n.brake_active = 1'b0;
    endcase
    n.throttle = thr_zero ? '0 : thr_y;

    // quick inversion
    n.belly_prev = belly_sw;
    unique case (qi_mode)
      QI_TIMED: begin
        if (belly_sw && !r.belly_prev) begin
          n.qi_active = 1'b1;
          n.qi_ms = '0;
        end else if (r.qi_active && r.tick) begin
          if (r.qi_ms >= r.times[TOP_LSB +: 16]) begin
            n.qi_active = 1'b0;
          end else begin
            n.qi_ms = 16'(r.qi_ms + 16'h0001);
          end
        end
      end
      QI_UNTIMED: n.qi_active = belly_sw;
      QI_NONE: n.qi_active = 1'b0;
      default: n.qi_active = 1'b0;
    endcase

    // register port
    if (wr_in) begin
      unique case (addr_in)
        ADDR_CFG: n.cfg_shadow = wdata_in[CFG_W-1:0];
        ADDR_COMMIT: n.cfg = r.cfg_shadow;
        ADDR_BRK: n.brk_par = wdata_in[15:0];
        ADDR_LIMITS: n.limits = wdata_in[15:0];
        ADDR_THR: n.thr_par = wdata_in[23:0];
        ADDR_TIMES: n.times = wdata_in;
        ADDR_VACC: n.vacc = wdata_in[15:0];
        ADDR_CAL: begin
          n.cal_refused = pedal_mode != PEDAL_ANALOG;
          if (pedal_mode == PEDAL_ANALOG) begin
            if (wdata_in[CAL_LOW_BIT]) begin
              if (in4_sel != IN4_SERVICE_BRAKE || svc_sw) begin
                n.brk_min = brake_pot_in;
              end else begin
                n.cal_refused = 1'b1;
              end
            end
            if (wdata_in[CAL_HIGH_BIT]) begin
              n.brk_max = brake_pot_in;
            end
          end
        end
        default: n.rdata = '0;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CFG: n.rdata = 32'(r.cfg_shadow);
        ADDR_COMMIT: n.rdata = 32'(r.cfg);
        ADDR_BRK: n.rdata = 32'(r.brk_par);
        ADDR_LIMITS: n.rdata = 32'(r.limits);
        ADDR_THR: n.rdata = 32'(r.thr_par);
        ADDR_TIMES: n.rdata = r.times;
        ADDR_VACC: n.rdata = 32'(r.vacc);
        ADDR_CAL: n.rdata = 32'({r.brk_max, r.brk_min});
        ADDR_STATUS: n.rdata = {8'h00, r.brake_level, batt_level_in,
                                1'b0, r.qi_active, r.ramp_st, r.cal_refused,
                                r.moving, r.temp_warn, r.batt_alarm};
        ADDR_HOURS: n.rdata = 32'(hours);
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      r <= '0;
      r.vacc <= VACC_RST;
      r.limits <= LIMITS_RST;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign rdata_out = r.rdata;
  assign tiller_req_out = r.remap[0];
  assign seat_occ_out = r.remap[1];
  assign thermal_sel_out = r.remap[2];
  assign speed_cutback_one_out = r.remap[3];
  assign handbrake_out = r.remap[4];
  assign speed_cutback_two_out = r.remap[5];
  assign inch_fwd_out = r.remap[6];
  assign speed_cutback_three_out = r.remap[7];
  assign inch_bwd_out = r.remap[8];
  assign service_brake_out = r.remap[9];
  assign excl_steer_req_out = r.remap[10];
  assign aux_coil_out = r.aux_coil;
  assign steer_contactor_out = r.steer_cont;
  assign ramp_hold_out = r.ramp_hold;
  assign bridge_release_out = r.bridge_release;
  assign batt_alarm_out = r.batt_alarm;
  assign current_limit_out = r.cur_limit;
  assign temp_warn_out = r.temp_warn;
  assign qi_active_out = r.qi_active;
  assign brake_active_out = r.brake_active;
  assign brake_level_out = r.brake_level;
  assign throttle_out = r.throttle;
endmodule : tocf_option_ctrl

// >>> sim/tocf_monitor.sv
// Purpose: port assertions for the option controller
// Assumes: ce_in held high
// Notes: bound to the top module at the file end
`timescale 1ns/1ps
module tocf_monitor import tocf_pkg::*; (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic presence_in,
  input wire logic cfg_in1_in,
  input wire logic cfg_in2_in,
  input wire logic cfg_in4_in,
  input wire logic [7:0] batt_level_in,
  input wire logic tiller_req_out,
  input wire logic seat_occ_out,
  input wire logic thermal_sel_out,
  input wire logic speed_cutback_one_out,
  input wire logic speed_cutback_two_out,
  input wire logic handbrake_out,
  input wire logic inch_fwd_out,
  input wire logic service_brake_out,
  input wire logic excl_steer_req_out,
  input wire logic batt_alarm_out,
  input wire logic temp_warn_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_pres; (tiller_req_out || seat_occ_out) |-> $past(presence_in); endproperty
  a_pres: assert property (p_pres) else $error("presence role without pin");
  property p_drop; !presence_in |=> !tiller_req_out && !seat_occ_out; endproperty
  a_drop: assert property (p_drop) else $error("presence role stuck");
  property p_in1; (speed_cutback_one_out || handbrake_out) |-> $past(cfg_in1_in); endproperty
  a_in1: assert property (p_in1) else $error("input one without pin");
  property p_sel1; $onehot0({thermal_sel_out, speed_cutback_one_out, handbrake_out}); endproperty
  a_sel1: assert property (p_sel1) else $error("input one two roles");
  property p_in2; (speed_cutback_two_out || inch_fwd_out) |-> $past(cfg_in2_in); endproperty
  a_in2: assert property (p_in2) else $error("input two without pin");
  property p_in4; !cfg_in4_in |=> !service_brake_out && !excl_steer_req_out; endproperty
  a_in4: assert property (p_in4) else $error("input four stuck");
  property p_batt; batt_alarm_out |-> $past(batt_level_in) <= BATT_LOW_PCT; endproperty
  a_batt: assert property (p_batt) else $error("alarm above low level");
  property p_warn; temp_warn_out |-> thermal_sel_out; endproperty
  a_warn: assert property (p_warn) else $error("warning without sensor");
  c_tiller: cover property (tiller_req_out);
  c_alarm: cover property (batt_alarm_out);
  c_inch: cover property (inch_fwd_out);
endmodule : tocf_monitor
bind tocf_option_ctrl tocf_monitor mon (.*);

// >>> sim/tocf_enc_model.sv
// Purpose: quadrature encoder on the motor shaft
// Assumes: one step every second clock while run_in is high
// Notes: phases hold their level when stopped
`timescale 1ns/1ps
module tocf_enc_model (
  input wire logic core_clk_in,
  input wire logic run_in,
  output logic enc_a_out,
  output logic enc_b_out
);
  logic [2:0] ph_r = 3'h0;
  always @(posedge core_clk_in) begin
    if (run_in) begin
      ph_r <= ph_r + 3'h1;
    end
  end
  // gray order keeps the edges a quarter period apart
  assign enc_a_out = ph_r[2];
  assign enc_b_out = ph_r[2] ^ ph_r[1];
endmodule : tocf_enc_model

// >>> sim/tb_tocf_option_ctrl.sv
// Purpose: self-checking bench for the option controller
// Assumes: tick of 4 cycles, hour of 10 ticks
// Notes: remap rows first, then hand tests
`timescale 1ns/1ps
module tb_tocf_option_ctrl import tocf_pkg::*;;
  logic core_clk_in = 1'h0, resetn_in = 1'h0, ce_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
  logic key_in = 1'h0, fwd_in = 1'h0, bwd_in = 1'h0, presence_in = 1'h0, enc_run = 1'h0;
  logic cfg_in1_in = 1'h0, cfg_in2_in = 1'h0, cfg_in3_in = 1'h0, cfg_in4_in = 1'h0;
  logic [7:0] addr_in = 8'h00, accel_pot_in = 8'h00, brake_pot_in = 8'h00;
  logic [7:0] motor_temp_in = 8'h00, batt_level_in = 8'h64;
  logic [31:0] wdata_in = 32'h0, rd_v, rdata_out;
  logic enc_a_in, enc_b_in, tiller_req_out, seat_occ_out, thermal_sel_out;
  logic speed_cutback_one_out, speed_cutback_two_out, speed_cutback_three_out;
  logic handbrake_out, inch_fwd_out, inch_bwd_out, service_brake_out, excl_steer_req_out;
  logic aux_coil_out, steer_contactor_out, ramp_hold_out, bridge_release_out;
  logic batt_alarm_out, temp_warn_out, qi_active_out, brake_active_out;
  logic [7:0] current_limit_out, brake_level_out, throttle_out;
  logic [10:0] remap_v;
  int num_errors = 0;
  int checked = 0;
  typedef struct {logic [16:0] cfg; logic [4:0] pins; logic [10:0] exp;} tocf_row_t;
  tocf_row_t rows [4] = '{'{17'h0, 5'h1F, 11'h560}, '{17'h3B, 5'h1F, 11'h28E},
    '{17'h44, 5'h1F, 11'h471}, '{17'h3B, 5'h0, 11'h0}};
  assign remap_v = {tiller_req_out, seat_occ_out, thermal_sel_out, speed_cutback_one_out,
    speed_cutback_two_out, speed_cutback_three_out, handbrake_out, inch_fwd_out,
    inch_bwd_out, service_brake_out, excl_steer_req_out};
  always #10 core_clk_in = ~core_clk_in;
  tocf_option_ctrl #(.TICK_CYCLES(4), .TICKS_PER_HOUR(10)) dut (.*);
  tocf_enc_model enc (.core_clk_in(core_clk_in), .run_in(enc_run), .enc_a_out(enc_a_in),
    .enc_b_out(enc_b_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    wt(1);
    wr_in <= 1'h0;
    wt(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    addr_in <= a;
    rd_in <= 1'h1;
    wt(1);
    rd_in <= 1'h0;
    #1 rd_v = rdata_out;
    wt(1);
  endtask : rd
  task automatic cfg(input logic [16:0] v);
    wr(ADDR_CFG, {15'h0, v});
    wr(ADDR_COMMIT, 32'h0);
    wt(2);
  endtask : cfg
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    wt(20000);
    num_errors++;
    finish_test();
  end
  initial begin
    wt(2);
    resetn_in <= 1'h1;
    rd(ADDR_COMMIT);
    chk("cfg reset", 32'h0, rd_v);
    chk("limit reset", 32'hFF, {24'h0, current_limit_out});
    foreach (rows[i]) begin
      cfg(rows[i].cfg);
      {presence_in, cfg_in1_in, cfg_in2_in, cfg_in3_in, cfg_in4_in} <= rows[i].pins;
      wt(3);
      chk("remap", {21'h0, rows[i].exp}, {21'h0, remap_v});
    end
    $display("remap rows done");
    presence_in <= 1'h1;
    cfg(17'h0);
    wr(ADDR_CFG, 32'h1);
    wt(2);
    chk("shadow only", 32'h1, {31'h0, tiller_req_out});
    wr(ADDR_COMMIT, 32'h0);
    wt(2);
    chk("after commit", 32'h1, {31'h0, seat_occ_out});
    rd(8'h3C);
    chk("unmapped", 32'h0, rd_v);
    key_in <= 1'h1;
    cfg(17'h0);
    wt(100);
    rd(ADDR_HOURS);
    chk("hours travel", 32'h0, rd_v);
    cfg(17'h80);
    wt(60);
    rd(ADDR_HOURS);
    chk("hours key", 32'h1, rd_v);
    $display("commit and hours done");
    wr(ADDR_LIMITS, 32'h5080);
    batt_level_in <= BATT_LOW_PCT;
    cfg(17'h0);
    chk("check off", 32'h80, {batt_alarm_out, current_limit_out});
    rd(ADDR_STATUS);
    chk("level", 32'h0A, {24'h0, rd_v[15:8]});
    cfg(17'h100);
    chk("check on", 32'h140, {batt_alarm_out, current_limit_out});
    batt_level_in <= 8'h0B;
    wt(3);
    chk("above low", 32'h80, {batt_alarm_out, current_limit_out});
    motor_temp_in <= 8'h50;
    wt(3);
    chk("temp at", 32'h0, {31'h0, temp_warn_out});
    motor_temp_in <= 8'h51;
    wt(3);
    chk("temp above", 32'h1, {31'h0, temp_warn_out});
    $display("battery and temp done");
    wr(ADDR_BRK, 32'hC010);
    cfg(17'h2020);
    cfg_in4_in <= 1'h1;
    wt(40);
    chk("digital", 32'h1C0, {brake_active_out, brake_level_out});
    cfg(17'h20);
    wt(40);
    chk("no pedal", 32'h0, {31'h0, brake_active_out});
    brake_pot_in <= 8'h20;
    wr(ADDR_CAL, 32'h1);
    rd(ADDR_STATUS);
    chk("cal refused", 32'h1, {31'h0, rd_v[3]});
    cfg(17'h4000);
    wr(ADDR_CAL, 32'h1);
    brake_pot_in <= 8'hA0;
    wr(ADDR_CAL, 32'h2);
    rd(ADDR_CAL);
    chk("cal", 32'hA020, rd_v);
    brake_pot_in <= 8'h60;
    wt(40);
    chk("analog mid", 32'h168, {brake_active_out, brake_level_out});
    cfg(17'h4020);
    cfg_in4_in <= 1'h0;
    brake_pot_in <= 8'h20;
    wt(40);
    chk("switch open", 32'h0, {31'h0, brake_active_out});
    cfg_in4_in <= 1'h1;
    wt(40);
    chk("switch closed", 32'h110, {brake_active_out, brake_level_out});
    $display("braking done");
    wr(ADDR_THR, 32'h804020);
    accel_pot_in <= 8'h20;
    wt(40);
    chk("deadband", 32'h0, {24'h0, throttle_out});
    accel_pot_in <= 8'h40;
    wt(40);
    chk("x point", 32'h80, {24'h0, throttle_out});
    accel_pot_in <= 8'h00;
    cfg(17'h10000);
    chk("qi untimed", 32'h1, {31'h0, qi_active_out});
    cfg(17'h0);
    chk("qi none", 32'h0, {31'h0, qi_active_out});
    cfg(17'h1840);
    chk("aux free", 32'h0, {31'h0, aux_coil_out});
    cfg(17'h1040);
    chk("excl steer", 32'h1, {31'h0, aux_coil_out});
    cfg(17'h200);
    chk("key brake mode", 32'h0, {31'h0, steer_contactor_out});
    cfg(17'hA00);
    chk("key steer", 32'h1, {31'h0, steer_contactor_out});
    cfg_in4_in <= 1'h0;
    cfg(17'h800);
    chk("no request", 32'h0, {31'h0, steer_contactor_out});
    fwd_in <= 1'h1;
    wt(3);
    chk("direction", 32'h1, {31'h0, steer_contactor_out});
    fwd_in <= 1'h0;
    enc_run <= 1'h1;
    wt(20);
    chk("movement", 32'h1, {31'h0, steer_contactor_out});
    wr(ADDR_TIMES, 32'h30005);
    cfg(17'h400);
    fwd_in <= 1'h1;
    wt(3);
    fwd_in <= 1'h0;
    wt(4);
    chk("ramp hold", 32'h5, {ramp_hold_out, bridge_release_out, aux_coil_out});
    wt(40);
    chk("ramp done", 32'h2, {ramp_hold_out, bridge_release_out, aux_coil_out});
    cfg(17'h8000);
    cfg_in4_in <= 1'h1;
    wt(3);
    chk("qi timed", 32'h1, {31'h0, qi_active_out});
    wt(30);
    chk("qi expired", 32'h0, {31'h0, qi_active_out});
    $display("aux output done");
    finish_test();
  end
endmodule : tb_tocf_option_ctrl
